// file: src/icc_pkg.sv
// Shared constants, carrier types and address helpers for the instruction cache.
package icc_pkg;

  // Fetch address layout: 24-bit byte address, 32-bit words, 4-word lines.
  localparam int ADDR_W       = 24;
  localparam int DATA_W       = 32;
  localparam int WORD_LSB     = 2;
  localparam int LINE_LSB     = 4;
  localparam int WAYS         = 2;
  localparam int RAMSETS      = 2;
  localparam int WAY_LINES    = 512;
  localparam int RS_LINES     = 256;
  localparam int WAY_TAG_LSB  = 13;
  localparam int WAY_TAG_W    = 11;
  localparam int RS_TAG_LSB   = 12;
  localparam int RS_TAG_W     = 12;

  // Timing in core clock cycles.
  localparam int HIT_SEQ_CYC  = 1;
  localparam int HIT_INIT_CYC = 2;
  localparam int MISS_FWD_CYC = 4;
  localparam int MISS_DLV_CYC = 3;
  localparam int ENABLE_CYC   = 4;
  localparam int FLUSH_CYC    = 2;

  // Counter loads and end counts; a down-counter fires the cycle after it has reached zero.
  localparam logic [1:0] FWD_LOAD   = 2'(MISS_FWD_CYC - 2);
  localparam logic [1:0] DLV_LOAD   = 2'(MISS_DLV_CYC - 2);
  localparam logic [2:0] EN_LAST    = 3'(ENABLE_CYC - 1);
  localparam logic [1:0] FLUSH_LOAD = 2'(FLUSH_CYC - 1);
  localparam logic [1:0] LAST_WORD  = 2'h3;

  // Reset values of the control state.
  localparam logic FREEZE_RST  = 1'b0;
  localparam logic ENABLED_RST = 1'b0;

  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } icc_fetch_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } icc_word_t;

  function automatic logic [8:0] way_index(input logic [ADDR_W-1:0] a);
    return a[12:LINE_LSB];
  endfunction : way_index

  function automatic logic [7:0] rs_index(input logic [ADDR_W-1:0] a);
    return a[11:LINE_LSB];
  endfunction : rs_index

  function automatic logic [ADDR_W-1:0] line_base(
    input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:LINE_LSB], 4'h0};
  endfunction : line_base

endpackage : icc_pkg

// file: src/icc_ctl_seq.sv
// Enable sequencing and flush-busy timing for the instruction cache.
`timescale 1ns/1ps
module icc_ctl_seq (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Core control bits
  input  wire logic cache_on,
  input  wire logic flush_wr,
  // Status
  output logic      enabled,
  output logic      flush_busy
);
  import icc_pkg::*;

  logic [2:0] en_cnt;
  logic [2:0] next_en_cnt;
  logic       next_enabled;
  logic [1:0] fl_cnt;
  logic [1:0] next_fl_cnt;
  logic       next_flush_busy;

  // Enabling takes several cycles; disabling is immediate.
  always_comb begin
    next_en_cnt  = 3'h0;
    next_enabled = 1'b0;
    if (cache_on) begin
      next_enabled = enabled || (en_cnt == EN_LAST);
      next_en_cnt  = next_enabled ? en_cnt : en_cnt + 3'h1;
    end
  end

  always_comb begin
    next_fl_cnt     = fl_cnt;
    next_flush_busy = flush_busy;
    if (flush_wr) begin
      next_flush_busy = 1'b1;
      next_fl_cnt     = FLUSH_LOAD;
    end else if (flush_busy) begin
      if (fl_cnt == 2'h0) begin
        next_flush_busy = 1'b0;
      end else begin
        next_fl_cnt = fl_cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_cnt     <= 3'h0;
      enabled    <= ENABLED_RST;
      fl_cnt     <= 2'h0;
      flush_busy <= 1'b0;
    end else begin
      en_cnt     <= next_en_cnt;
      enabled    <= next_enabled;
      fl_cnt     <= next_fl_cnt;
      flush_busy <= next_flush_busy;
    end
  end

  property p_en_wait;
    @(posedge clk) disable iff (!rst_n)
    $rose(cache_on) && !enabled |-> !enabled [*4];
  endproperty
  a_en_wait: assert property (p_en_wait) else $error("enable too early");

  property p_en_off;
    @(posedge clk) disable iff (!rst_n)
    !cache_on |=> !enabled;
  endproperty
  a_en_off: assert property (p_en_off) else $error("enabled while off");

  property p_flush_busy;
    @(posedge clk) disable iff (!rst_n)
    flush_wr |=> flush_busy [*2];
  endproperty
  a_flush_busy: assert property (p_flush_busy) else $error("flush busy short");

endmodule : icc_ctl_seq

// file: src/icc_top.sv
// Instruction cache: lookup, line fill, freeze, flush and debug access.
`timescale 1ns/1ps
// Functional notes
// - Freeze locks lines, tags and valid bits against fills; flush and breakpoints still clear valid bits.
// - Frozen cache still hits on old lines; misses do not update arrays.
// - Reset leaves the cache unfrozen.
// - Frozen miss still fetches four words, delivers one, drops the rest.
// - Two-way cache alone, with one or with two RAM sets.
// - Reset leaves cache unconfigured; software reconfigures every time.
// - Everything runs on the one subsystem master clock.
// - Idle or disabled cache passes fetches to memory without lookup.
// - Emulator reads of contents change nothing.
// - Breakpoint set or removed invalidates the line holding it.
// - Initial hit delivers its word in two cycles.
// - Consecutive sequential hit takes one cycle, other hits two.
// - A miss requests all four words of the line.
// - Four cycles from taking a miss to forwarding it.
// - Three cycles from requested word arrival to delivery.
// - Requested word goes to the core without waiting for the line to complete.
// - Line words are fetched in order starting at word zero.
// - Enabled status rises only after internal enabling completes.
// - Hit needs a tag match and a set valid bit.
// - Enable bit turns lookups on and off; reset clears it.
// - Flush clears all valid bits; busy reads one until done.
module icc_top (
  // Clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_N,
  // Core status bits and configuration
  input  wire logic                  CACHE_ON,
  input  wire logic                  CACHE_FREEZE,
  input  wire logic                  CACHE_FLUSH_WR,
  input  wire logic                  CACHE_IDLE,
  input  wire logic [1:0]            RAMSETS_USED,
  input  wire logic [1:0]            RS_TAG_WR,
  input  wire logic [11:0]           RS_TAG,
  // Core fetch port
  input  wire icc_pkg::icc_fetch_t   FETCH,
  output logic                       FETCH_READY,
  output icc_pkg::icc_word_t         FETCH_RSP,
  // External memory port
  output logic                       MEM_REQ,
  output logic [23:0]                MEM_ADDR,
  input  wire icc_pkg::icc_word_t    MEM_RSP,
  // Debug and emulation
  input  wire logic                  BKPT_INV,
  input  wire logic [23:0]           BKPT_ADDR,
  input  wire logic                  EMU_RD,
  input  wire logic [1:0]            EMU_SEL,
  input  wire logic [23:0]           EMU_ADDR,
  output logic [31:0]                EMU_DATA,
  // Status
  output logic                       CACHE_ENABLED,
  output logic                       FLUSH_BUSY,
  output logic [1:0]                 RS_TAG_VALID
);
  import icc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_HIT2 = 4'h2,
    S_FWD  = 4'h4,
    S_FILL = 4'h8
  } icc_state_t;

  // Storage arrays; no reset, validity is held in the valid vectors.
  logic [31:0]          way_mem [WAYS][WAY_LINES*4];
  logic [31:0]          rs_mem  [RAMSETS][RS_LINES*4];
  logic [10:0]          way_tag [WAYS][WAY_LINES];

  icc_state_t           state, next_state;
  logic [1:0]           cnt, next_cnt, dcnt, next_dcnt;
  logic [1:0]           word_idx, next_word_idx;
  logic                 dpend, next_dpend, got_all, next_got_all;
  logic                 dl_done, next_dl_done;
  logic [23:0]          req_addr, next_req_addr;
  logic                 req_bypass, next_req_bypass;
  logic                 tgt_rs, next_tgt_rs, tgt_sel, next_tgt_sel;
  logic [31:0]          data_hold, next_data_hold;
  logic [21:0]          last_word, next_last_word;
  icc_word_t            next_fetch_rsp;
  logic                 next_fetch_ready;
  logic                 next_mem_req;
  logic [23:0]          next_mem_addr;
  logic [31:0]          next_emu_data;
  logic                 frz;
  logic [1:0][511:0]    way_valid, next_way_valid;
  logic [1:0][255:0]    rs_valid, next_rs_valid;
  logic [1:0][11:0]     rs_tag, next_rs_tag;
  logic [1:0]           next_rs_tag_valid;
  logic [511:0]         lru, next_lru;

  logic                 enabled;
  logic                 lookup_on, take, seq, hit;
  logic [1:0]           rs_match, rs_hit, way_hit;
  logic [31:0]          hit_word;
  logic                 fill_we, tag_we;
  logic [8:0]           f_widx, q_widx, bk_widx;
  logic [7:0]           f_ridx, q_ridx, bk_ridx;

  icc_ctl_seq u_ctl (
    .clk        (REF_CLK),
    .rst_n      (RST_N),
    .cache_on   (CACHE_ON),
    .flush_wr   (CACHE_FLUSH_WR),
    .enabled    (enabled),
    .flush_busy (FLUSH_BUSY)
  );

  assign CACHE_ENABLED = enabled;
  assign f_widx  = way_index(FETCH.addr);
  assign f_ridx  = rs_index(FETCH.addr);
  assign q_widx  = way_index(req_addr);
  assign q_ridx  = rs_index(req_addr);
  assign bk_widx = way_index(BKPT_ADDR);
  assign bk_ridx = rs_index(BKPT_ADDR);
  assign lookup_on = enabled && !CACHE_IDLE;
  assign take = FETCH.req && FETCH_READY;
  assign seq  = FETCH_RSP.valid && (FETCH.addr[23:2] == last_word + 22'h1);

  // Presence check over the enabled RAM sets and both ways.
  always_comb begin
    hit_word = 32'h0;
    for (int w = 0; w < WAYS; w++) begin
      way_hit[w] = way_valid[w][f_widx] &&
                   (way_tag[w][f_widx] == FETCH.addr[23:13]);
      if (way_hit[w]) begin
        hit_word = way_mem[w][{f_widx, FETCH.addr[3:2]}];
      end
    end
    for (int s = 0; s < RAMSETS; s++) begin
      rs_match[s] = (2'(s) < RAMSETS_USED) && RS_TAG_VALID[s] &&
                    (rs_tag[s] == FETCH.addr[23:12]);
      rs_hit[s]   = rs_match[s] && rs_valid[s][f_ridx];
      if (rs_hit[s]) begin
        hit_word = rs_mem[s][{f_ridx, FETCH.addr[3:2]}];
      end
    end
    hit = lookup_on && ((|rs_hit) || (|way_hit));
  end

  // Frozen or bypassed fills deliver the word but write nothing.
  assign fill_we = (state == S_FILL) && MEM_RSP.valid && !got_all &&
                   !frz && !req_bypass;
  assign tag_we  = fill_we && (word_idx == LAST_WORD);

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_dcnt        = dcnt;
    next_word_idx    = word_idx;
    next_dpend       = dpend;
    next_got_all     = got_all;
    next_dl_done     = dl_done;
    next_req_addr    = req_addr;
    next_req_bypass  = req_bypass;
    next_tgt_rs      = tgt_rs;
    next_tgt_sel     = tgt_sel;
    next_data_hold   = data_hold;
    next_last_word   = last_word;
    next_fetch_rsp   = '{valid: 1'b0, data: FETCH_RSP.data};
    next_mem_req     = 1'b0;
    next_mem_addr    = MEM_ADDR;
    next_lru         = lru;
    case (state)
      S_IDLE: begin
        if (take) begin
          next_req_addr   = FETCH.addr;
          next_req_bypass = !lookup_on;
          if (hit && seq) begin
            next_fetch_rsp = '{valid: 1'b1, data: hit_word};
            next_last_word = FETCH.addr[23:2];
          end else if (hit) begin
            next_data_hold = hit_word;
            next_state     = S_HIT2;
          end else begin
            next_state    = S_FWD;
            next_cnt      = FWD_LOAD;
            next_word_idx = 2'h0;
            next_dpend    = 1'b0;
            next_got_all  = 1'b0;
            next_dl_done  = 1'b0;
            next_tgt_rs   = |rs_match;
            next_tgt_sel  = rs_match[1] ? 1'b1 :
                            (rs_match[0] ? 1'b0 : lru[f_widx]);
          end
          if (hit && !(|rs_hit)) begin
            next_lru[f_widx] = !way_hit[1];
          end
        end
      end
      S_HIT2: begin
        next_fetch_rsp = '{valid: 1'b1, data: data_hold};
        next_last_word = req_addr[23:2];
        next_state     = S_IDLE;
      end
      S_FWD: begin
        if (cnt == 2'h0) begin
          next_mem_req  = 1'b1;
          next_mem_addr = line_base(req_addr);
          next_state    = S_FILL;
        end else begin
          next_cnt = cnt - 2'h1;
        end
      end
      S_FILL: begin
        if (dpend) begin
          if (dcnt == 2'h0) begin
            next_fetch_rsp = '{valid: 1'b1, data: data_hold};
            next_last_word = req_addr[23:2];
            next_dpend     = 1'b0;
            next_dl_done   = 1'b1;
          end else begin
            next_dcnt = dcnt - 2'h1;
          end
        end
        if (MEM_RSP.valid && !got_all) begin
          // Word goes out three cycles after it lands, without waiting for the line.
          if (word_idx == req_addr[3:2]) begin
            next_data_hold = MEM_RSP.data;
            next_dpend     = 1'b1;
            next_dcnt      = DLV_LOAD;
          end
          next_got_all  = (word_idx == LAST_WORD);
          next_word_idx = word_idx + 2'h1;
          if (tag_we && !tgt_rs) begin
            next_lru[q_widx] = !tgt_sel;
          end
        end
        if (next_got_all && next_dl_done) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    next_fetch_ready = (next_state == S_IDLE);
  end

  // Valid and tag state; flush is applied last so it always wins.
  always_comb begin
    next_way_valid    = way_valid;
    next_rs_valid     = rs_valid;
    next_rs_tag       = rs_tag;
    next_rs_tag_valid = RS_TAG_VALID;
    if (tag_we) begin
      if (tgt_rs) begin
        next_rs_valid[tgt_sel][q_ridx] = 1'b1;
      end else begin
        next_way_valid[tgt_sel][q_widx] = 1'b1;
      end
    end
    for (int s = 0; s < RAMSETS; s++) begin
      if (RS_TAG_WR[s] && enabled && !frz) begin
        next_rs_tag[s]       = RS_TAG;
        next_rs_tag_valid[s] = 1'b1;
        next_rs_valid[s]     = '0;
      end
    end
    if (BKPT_INV) begin
      for (int w = 0; w < WAYS; w++) begin
        next_way_valid[w][bk_widx] = 1'b0;
        next_rs_valid[w][bk_ridx]  = 1'b0;
      end
    end
    if (CACHE_FLUSH_WR) begin
      next_way_valid    = '0;
      next_rs_valid     = '0;
      next_rs_tag_valid = 2'h0;
    end
  end

  // Emulator read path only looks; it feeds nothing back.
  always_comb begin
    next_emu_data = EMU_DATA;
    if (EMU_RD) begin
      next_emu_data = EMU_SEL[1] ?
        rs_mem[EMU_SEL[0]][{rs_index(EMU_ADDR), EMU_ADDR[3:2]}] :
        way_mem[EMU_SEL[0]][{way_index(EMU_ADDR), EMU_ADDR[3:2]}];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (fill_we) begin
      if (tgt_rs) begin
        rs_mem[tgt_sel][{q_ridx, word_idx}] <= MEM_RSP.data;
      end else begin
        way_mem[tgt_sel][{q_widx, word_idx}] <= MEM_RSP.data;
      end
    end
    if (tag_we && !tgt_rs) begin
      way_tag[tgt_sel][q_widx] <= req_addr[23:13];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state        <= S_IDLE;
      cnt          <= 2'h0;
      dcnt         <= 2'h0;
      word_idx     <= 2'h0;
      dpend        <= 1'b0;
      got_all      <= 1'b0;
      dl_done      <= 1'b0;
      req_addr     <= 24'h0;
      req_bypass   <= 1'b0;
      tgt_rs       <= 1'b0;
      tgt_sel      <= 1'b0;
      data_hold    <= 32'h0;
      last_word    <= 22'h0;
      FETCH_RSP    <= '0;
      FETCH_READY  <= 1'b0;
      MEM_REQ      <= 1'b0;
      MEM_ADDR     <= 24'h0;
      EMU_DATA     <= 32'h0;
      frz          <= FREEZE_RST;
      way_valid    <= '0;
      rs_valid     <= '0;
      rs_tag       <= '0;
      RS_TAG_VALID <= 2'h0;
      lru          <= '0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      dcnt         <= next_dcnt;
      word_idx     <= next_word_idx;
      dpend        <= next_dpend;
      got_all      <= next_got_all;
      dl_done      <= next_dl_done;
      req_addr     <= next_req_addr;
      req_bypass   <= next_req_bypass;
      tgt_rs       <= next_tgt_rs;
      tgt_sel      <= next_tgt_sel;
      data_hold    <= next_data_hold;
      last_word    <= next_last_word;
      FETCH_RSP    <= next_fetch_rsp;
      FETCH_READY  <= next_fetch_ready;
      MEM_REQ      <= next_mem_req;
      MEM_ADDR     <= next_mem_addr;
      EMU_DATA     <= next_emu_data;
      frz          <= CACHE_FREEZE;
      way_valid    <= next_way_valid;
      rs_valid     <= next_rs_valid;
      rs_tag       <= next_rs_tag;
      RS_TAG_VALID <= next_rs_tag_valid;
      lru          <= next_lru;
    end
  end

  property p_hit_seq;
    @(posedge REF_CLK) disable iff (!RST_N)
    take && hit && seq |=> FETCH_RSP.valid;
  endproperty
  a_hit_seq: assert property (p_hit_seq) else $error("seq hit slow");

  property p_hit_init;
    @(posedge REF_CLK) disable iff (!RST_N)
    take && hit && !seq |=> !FETCH_RSP.valid ##1 FETCH_RSP.valid;
  endproperty
  a_hit_init: assert property (p_hit_init) else $error("hit not 2 cycles");

  property p_miss_fwd;
    @(posedge REF_CLK) disable iff (!RST_N)
    take && !hit |=> !MEM_REQ [*3] ##1 (MEM_REQ && MEM_ADDR[3:0] == 4'h0);
  endproperty
  a_miss_fwd: assert property (p_miss_fwd) else $error("miss fwd timing");

  property p_miss_dlv;
    @(posedge REF_CLK) disable iff (!RST_N)
    (state == S_FILL) && MEM_RSP.valid && !got_all &&
    (word_idx == req_addr[3:2]) |=> !FETCH_RSP.valid [*2] ##1 FETCH_RSP.valid;
  endproperty
  a_miss_dlv: assert property (p_miss_dlv) else $error("miss dlv timing");

  property p_freeze;
    @(posedge REF_CLK) disable iff (!RST_N)
    frz && !CACHE_FLUSH_WR && !BKPT_INV |=>
      $stable(way_valid) && $stable(rs_valid);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen state moved");

  property p_bypass;
    @(posedge REF_CLK) disable iff (!RST_N)
    take && !lookup_on |=> !FETCH_RSP.valid [*3] ##1 MEM_REQ;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass looked up");

  property p_emu;
    @(posedge REF_CLK) disable iff (!RST_N)
    EMU_RD && (state == S_IDLE) && !take && !CACHE_FLUSH_WR &&
    !BKPT_INV && (RS_TAG_WR == 2'h0) |=>
      $stable(way_valid) && $stable(rs_valid) && $stable(state);
  endproperty
  a_emu: assert property (p_emu) else $error("emu read changed state");

  property p_flush;
    @(posedge REF_CLK) disable iff (!RST_N)
    CACHE_FLUSH_WR |=> (way_valid == '0) && (rs_valid == '0) &&
      (RS_TAG_VALID == 2'h0);
  endproperty
  a_flush: assert property (p_flush) else $error("flush left valid");

  property p_bkpt;
    @(posedge REF_CLK) disable iff (!RST_N)
    BKPT_INV |=> !way_valid[0][$past(bk_widx)] && !way_valid[1][$past(bk_widx)];
  endproperty
  a_bkpt: assert property (p_bkpt) else $error("bkpt line valid");

endmodule : icc_top

// file: testbench/icc_mem_model.sv
// Memory-side model that answers line requests with four words.
`timescale 1ns/1ps
module icc_mem_model (
  // Clock and line request
  input  wire logic          clk,
  input  wire logic          mem_req,
  input  wire logic [23:0]   mem_addr,
  input  wire logic [3:0]    delay,
  // Returned words
  output icc_pkg::icc_word_t rsp
);
  import icc_pkg::*;
  logic [23:0] base;
  int          wait_cnt = 0;
  int          word_cnt = 4;
  initial rsp = '0;
  always @(posedge clk) begin
    // An idle bus drops valid and inverts the data each cycle, so stale data cannot match.
    rsp.valid <= 1'b0;
    rsp.data  <= ~rsp.data;
    if (mem_req) begin
      base     <= mem_addr;
      wait_cnt <= int'(delay);
      word_cnt <= 0;
    end else if (word_cnt < 4) begin
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else begin
        rsp.valid <= 1'b1;
        rsp.data  <= {8'h5A, base[23:4], 2'(word_cnt), 2'h0};
        word_cnt  <= word_cnt + 1;
      end
    end
  end
endmodule : icc_mem_model

// file: testbench/tb_top.sv
// Self-checking bench for the instruction cache and its memory model.
`timescale 1ns/1ps
module tb_top;
  import icc_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cache_on  = 1'b0;
  logic        freeze    = 1'b0;
  logic        flush_wr  = 1'b0;
  logic        idle      = 1'b0;
  logic        bkpt      = 1'b0;
  logic        emu_rd    = 1'b0;
  logic [1:0]  emu_sel   = 2'h0;
  logic [23:0] bkpt_addr = 24'h0;
  logic [23:0] emu_addr  = 24'h0;
  logic [3:0]  mem_dly   = 4'h0;
  logic        rs_wr     = 1'b0;
  logic [1:0]  rs_used   = 2'h0;
  logic [11:0] rs_tag    = 12'h0;
  logic [1:0]  rs_tag_valid;
  logic [31:0] rng       = 32'h36EE;
  icc_fetch_t  fetch     = '0;
  icc_word_t   fetch_rsp;
  icc_word_t   mem_rsp;
  logic        fetch_ready;
  logic        mem_req;
  logic        enabled;
  logic        flush_busy;
  logic [23:0] mem_addr;
  logic [31:0] emu_data;
  int          error_cnt = 0;
  int          compares  = 0;

  always #2.5 clk = ~clk;

  icc_top icc_top_inst (.REF_CLK(clk), .RST_N(rst_n), .CACHE_ON(cache_on),
    .CACHE_FREEZE(freeze), .CACHE_FLUSH_WR(flush_wr), .CACHE_IDLE(idle),
    .RAMSETS_USED(rs_used), .RS_TAG_WR({1'b0, rs_wr}), .RS_TAG(rs_tag),
    .FETCH(fetch),
    .FETCH_READY(fetch_ready), .FETCH_RSP(fetch_rsp), .MEM_REQ(mem_req),
    .MEM_ADDR(mem_addr), .MEM_RSP(mem_rsp), .BKPT_INV(bkpt),
    .BKPT_ADDR(bkpt_addr), .EMU_RD(emu_rd), .EMU_SEL(emu_sel),
    .EMU_ADDR(emu_addr), .EMU_DATA(emu_data), .CACHE_ENABLED(enabled),
    .FLUSH_BUSY(flush_busy), .RS_TAG_VALID(rs_tag_valid));
  icc_mem_model icc_mem_model_inst (.clk(clk), .mem_req(mem_req),
    .mem_addr(mem_addr), .delay(mem_dly), .rsp(mem_rsp));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [31:0] exp_word(input logic [23:0] a);
    return {8'h5A, a[23:2], 2'h0};
  endfunction : exp_word

  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // Kind: 0 miss or bypass, 1 plain hit, 2 sequential hit, 3 unknown.
  task automatic fetch_chk(input logic [23:0] a, input int kind);
    int lat;
    int mreq_at;
    int wlat;
    mreq_at = 0;
    wlat = 0;
    for (lat = 0; lat < 60 && fetch_ready !== 1'b1; lat++) @(negedge clk);
    fetch.req = 1'b1;
    fetch.addr = a;
    @(negedge clk);
    // A sequential hit answers at once, so req stays up for the next call.
    if (fetch_rsp.valid !== 1'b1) fetch.req = 1'b0;
    lat = 1;
    while (fetch_rsp.valid !== 1'b1 && lat < 60) begin
      if (mem_req === 1'b1) begin
        mreq_at = lat;
        chk("line address", 32'(mem_addr), {8'h0, a[23:4], 4'h0});
      end
      if (mem_rsp.valid === 1'b1 && mem_rsp.data === exp_word(a)) wlat = lat;
      @(negedge clk);
      lat++;
    end
    chk("fetch answered", 32'(fetch_rsp.valid), 32'h1);
    chk("fetch data", fetch_rsp.data, exp_word(a));
    if (kind == 0) begin
      chk("miss forward cycles", 32'(mreq_at), 32'h4);
      chk("miss delivery cycles", 32'(lat), 32'(wlat + 3));
    end else if (kind < 3) begin
      chk("hit memory request", 32'(mreq_at), 32'h0);
      chk("hit cycles", 32'(lat), 32'(3 - kind));
    end
  endtask : fetch_chk

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [23:0] a;
    logic [23:0] b;
    bit          found;
    a = 24'h001000;
    b = 24'h003000;
    found = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("enabled after reset", 32'(enabled), 32'h0);
    chk("flush after reset", 32'(flush_busy), 32'h0);
    fetch_chk(a, 0);
    cache_on = 1'b1;
    repeat (3) @(negedge clk);
    chk("enabled early", 32'(enabled), 32'h0);
    @(negedge clk);
    chk("enabled", 32'(enabled), 32'h1);
    fetch_chk(a, 0);
    fetch_chk(a, 1);
    fetch_chk(a + 24'h4, 2);
    fetch_chk(a + 24'hC, 1);
    for (int i = 0; i < 4; i++) begin
      emu_sel = 2'(i);
      emu_addr = a;
      pulse(emu_rd);
      if (i < 2 && emu_data === exp_word(a)) found = 1'b1;
      @(negedge clk);
    end
    chk("emulator word", 32'(found), 32'h1);
    fetch_chk(a, 1);
    freeze = 1'b1;
    repeat (2) @(negedge clk);
    fetch_chk(b, 0);
    fetch_chk(b, 0);
    fetch_chk(a, 1);
    pulse(flush_wr);
    chk("flush busy", 32'(flush_busy), 32'h1);
    @(negedge clk);
    chk("flush busy", 32'(flush_busy), 32'h1);
    @(negedge clk);
    chk("flush done", 32'(flush_busy), 32'h0);
    freeze = 1'b0;
    repeat (2) @(negedge clk);
    fetch_chk(a, 0);
    fetch_chk(b, 0);
    fetch_chk(b, 1);
    bkpt_addr = b;
    pulse(bkpt);
    fetch_chk(b, 0);
    cache_on = 1'b0;
    @(negedge clk);
    chk("disabled", 32'(enabled), 32'h0);
    fetch_chk(a, 0);
    cache_on = 1'b1;
    idle = 1'b1;
    repeat (5) @(negedge clk);
    fetch_chk(a, 0);
    idle = 1'b0;
    @(negedge clk);
    fetch_chk(b, 1);
    for (int i = 0; i < 40; i++) begin
      rng = xs(rng);
      mem_dly = rng[15:12];
      a = {12'h020, rng[9:0], 2'h0};
      fetch_chk(a, 3);
      fetch_chk(a, 1);
    end
    cache_on = 1'b0;
    @(negedge clk);
    rs_used = 2'h1;
    @(negedge clk);
    cache_on = 1'b1;
    for (int i = 0; i < 20 && enabled !== 1'b1; i++) @(negedge clk);
    chk("enabled polled", 32'(enabled), 32'h1);
    rs_tag = 12'h040;
    pulse(rs_wr);
    chk("ram set tag valid", 32'(rs_tag_valid), 32'h1);
    fetch_chk(24'h040104, 0);
    fetch_chk(24'h040104, 1);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("tags after reset", 32'(rs_tag_valid), 32'h0);
    chk("enabled after reset", 32'(enabled), 32'h0);
    fetch_chk(24'h040104, 0);
    summarize();
  end
endmodule : tb_top
